// File: gocfg_cmd.sv
`default_nettype none
module gocfg_cmd #(
   parameter int NUM_OBJ = 16,
   parameter int IDX_W   = 4
) (
   // clock and reset
   input  wire logic                         clock_in,
   input  wire logic                         arst_n_in,
   // parsed command from the text front end
   input  wire logic                         cmd_valid_in,
   output logic                              cmd_ready_out,
   input  wire logic                         cmd_get_in,
   input  wire logic [IDX_W-1:0]             cmd_index_in,
   input  wire logic [gocfg_pkg::WC_W-1:0]   cmd_wild_in,
   input  wire logic [gocfg_pkg::KIND_W-1:0] cmd_datapoint_kind_in,
   input  wire logic [gocfg_pkg::LEN_W-1:0]  cmd_object_length_type_in,
   input  wire logic [gocfg_pkg::FLAG_W-1:0] cmd_object_flag_set_in,
   input  wire logic [gocfg_pkg::POL_W-1:0]  cmd_transmit_policy_in,
   input  wire logic [gocfg_pkg::POL_W-1:0]  cmd_indication_policy_in,
   input  wire logic [gocfg_pkg::DELAY_W-1:0] cmd_delay_in,
   // acknowledge stream to the text front end
   output logic                              resp_valid_out,
   input  wire logic                         resp_ready_in,
   output logic                              resp_is_char_out,
   output logic [gocfg_pkg::WORD_W-1:0]      resp_data_out,
   // per-object status query
   input  wire logic [IDX_W-1:0]             obj_sel_in,
   output logic                              obj_interop_out,
   output logic [gocfg_pkg::LEN_W-1:0]       obj_raw_length_out,
   output logic                              obj_timeout_en_out,
   output logic [1:0]                        obj_time_base_out,
   output logic [gocfg_pkg::DELAY_W-1:0]     obj_delay_out
);
   // ****************************************************
   // object table
   // ****************************************************
   logic [gocfg_pkg::KIND_W-1:0]  kind_q [NUM_OBJ];
   logic [gocfg_pkg::KIND_W-1:0]  kind_d [NUM_OBJ];
   logic [gocfg_pkg::LEN_W-1:0]   len_q  [NUM_OBJ];
   logic [gocfg_pkg::LEN_W-1:0]   len_d  [NUM_OBJ];
   logic [gocfg_pkg::FLAG_W-1:0]  flag_q [NUM_OBJ];
   logic [gocfg_pkg::FLAG_W-1:0]  flag_d [NUM_OBJ];
   logic [gocfg_pkg::POL_W-1:0]   tx_q   [NUM_OBJ];
   logic [gocfg_pkg::POL_W-1:0]   tx_d   [NUM_OBJ];
   logic [gocfg_pkg::POL_W-1:0]   ind_q  [NUM_OBJ];
   logic [gocfg_pkg::POL_W-1:0]   ind_d  [NUM_OBJ];
   logic [gocfg_pkg::DELAY_W-1:0] dly_q  [NUM_OBJ];
   logic [gocfg_pkg::DELAY_W-1:0] dly_d  [NUM_OBJ];
   logic                          accept;
   logic                          do_set;

   assign accept = cmd_valid_in && cmd_ready_out;
   assign do_set = accept && !cmd_get_in;

   // set writes only explicit fields; a wildcard index touches every object
   always_comb begin
      for (int i = 0; i < NUM_OBJ; i++) begin
         kind_d[i] = kind_q[i];
         len_d[i]  = len_q[i];
         flag_d[i] = flag_q[i];
         tx_d[i]   = tx_q[i];
         ind_d[i]  = ind_q[i];
         dly_d[i]  = dly_q[i];
         if (do_set && (cmd_wild_in[gocfg_pkg::WC_IDX] ||
                        cmd_index_in == IDX_W'(i))) begin
            if (!cmd_wild_in[gocfg_pkg::WC_KIND])  kind_d[i] = cmd_datapoint_kind_in;
            if (!cmd_wild_in[gocfg_pkg::WC_LEN])   len_d[i]  = cmd_object_length_type_in;
            if (!cmd_wild_in[gocfg_pkg::WC_FLAG])  flag_d[i] = cmd_object_flag_set_in;
            if (!cmd_wild_in[gocfg_pkg::WC_TX])    tx_d[i]   = cmd_transmit_policy_in;
            if (!cmd_wild_in[gocfg_pkg::WC_IND])   ind_d[i]  = cmd_indication_policy_in;
            if (!cmd_wild_in[gocfg_pkg::WC_DELAY]) dly_d[i]  = cmd_delay_in;
         end
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < NUM_OBJ; i++) begin
            kind_q[i] <= gocfg_pkg::KIND_RST;
            len_q[i]  <= gocfg_pkg::LEN_RST;
            flag_q[i] <= gocfg_pkg::FLAG_RST;
            tx_q[i]   <= gocfg_pkg::POL_RST;
            ind_q[i]  <= gocfg_pkg::POL_RST;
            dly_q[i]  <= gocfg_pkg::DELAY_RST;
         end
      end else begin
         kind_q <= kind_d;
         len_q  <= len_d;
         flag_q <= flag_d;
         tx_q   <= tx_d;
         ind_q  <= ind_d;
         dly_q  <= dly_d;
      end
   end

   // ****************************************************
   // status query, registered so downstream timers see clean levels
   // ****************************************************
   logic                          interop_d;
   logic [gocfg_pkg::LEN_W-1:0]   raw_len_d;
   logic                          tmo_en_d;
   logic [1:0]                    time_base_d;
   logic [gocfg_pkg::DELAY_W-1:0] delay_d;

   // mode decode of the selected object
   always_comb begin
      interop_d   = (kind_q[obj_sel_in] != '0) && (len_q[obj_sel_in] == '0);
      raw_len_d   = (kind_q[obj_sel_in] == '0) ? len_q[obj_sel_in] : '0;
      tmo_en_d    = (dly_q[obj_sel_in] != '0);
      time_base_d = tx_q[obj_sel_in][gocfg_pkg::TB_HI:gocfg_pkg::TB_LO];
      delay_d     = dly_q[obj_sel_in];
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         obj_interop_out    <= 1'b0;
         obj_raw_length_out <= gocfg_pkg::LEN_RST;
         obj_timeout_en_out <= 1'b0;
         obj_time_base_out  <= 2'h0;
         obj_delay_out      <= gocfg_pkg::DELAY_RST;
      end else begin
         obj_interop_out    <= interop_d;
         obj_raw_length_out <= raw_len_d;
         obj_timeout_en_out <= tmo_en_d;
         obj_time_base_out  <= time_base_d;
         obj_delay_out      <= delay_d;
      end
   end

   // ****************************************************
   // acknowledge sequencer
   // ****************************************************
   typedef enum logic [2:0] {
      GOCFG_IDLE, GOCFG_OPEN, GOCFG_CH0, GOCFG_CH1, GOCFG_CH2, GOCFG_CLOSE, GOCFG_FIELD
   } gocfg_state_t;

   gocfg_state_t                state_q, state_d;
   logic                        get_q, get_d;
   logic [2:0]                  fld_q, fld_d;
   logic [IDX_W-1:0]            idx_q, idx_d;
   logic                        step;
   logic [gocfg_pkg::WORD_W-1:0] word_q, word_d;

   // returned field k of the snapshot object, in the returned order
   function automatic logic [gocfg_pkg::WORD_W-1:0] field_word(input logic [2:0] k,
                                                              input logic [IDX_W-1:0] ix);
      case (k)
         3'h0:    field_word = {8'h00, kind_q[ix]};
         3'h1:    field_word = {8'h00, len_q[ix]};
         3'h2:    field_word = {8'h00, flag_q[ix]};
         3'h3:    field_word = tx_q[ix];
         3'h4:    field_word = ind_q[ix];
         default: field_word = dly_q[ix];
      endcase
   endfunction

   assign step          = resp_valid_out && resp_ready_in;
   assign cmd_ready_out = (state_q == GOCFG_IDLE); // one command in flight at a time

   always_comb begin
      state_d = state_q;
      get_d   = get_q;
      fld_d   = fld_q;
      idx_d   = idx_q;
      case (state_q)
         GOCFG_IDLE:  if (accept) begin
            state_d = GOCFG_OPEN;
            get_d   = cmd_get_in;
            idx_d   = cmd_index_in;
            fld_d   = 3'h0;
         end
         GOCFG_OPEN:  if (step) state_d = GOCFG_CH0;
         GOCFG_CH0:   if (step) state_d = GOCFG_CH1;
         GOCFG_CH1:   if (step) state_d = GOCFG_CH2;
         GOCFG_CH2:   if (step) state_d = GOCFG_CLOSE;
         GOCFG_CLOSE: if (step) state_d = get_q ? GOCFG_FIELD : GOCFG_IDLE;
         GOCFG_FIELD: if (step) begin
            fld_d = fld_q + 3'h1;
            if (fld_q == gocfg_pkg::NUM_FIELDS - 3'h1) state_d = GOCFG_IDLE;
         end
         default:     state_d = GOCFG_IDLE;
      endcase
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= GOCFG_IDLE;
         get_q   <= 1'b0;
         fld_q   <= 3'h0;
         idx_q   <= '0;
         word_q  <= '0;
      end else begin
         state_q <= state_d;
         get_q   <= get_d;
         fld_q   <= fld_d;
         idx_q   <= idx_d;
         word_q  <= word_d;
      end
   end

   // next word picked from the next state so the data output is a flop;
   // the table cannot change while busy, so a field read one cycle early is current
   always_comb begin
      resp_valid_out   = (state_q != GOCFG_IDLE);
      resp_is_char_out = (state_q != GOCFG_FIELD);
      case (state_d)
         GOCFG_OPEN:  word_d = {8'h00, gocfg_pkg::CH_OPEN};
         GOCFG_CH0:   word_d = {8'h00, gocfg_pkg::CH_O};
         GOCFG_CH1:   word_d = {8'h00, gocfg_pkg::CH_C};
         GOCFG_CH2:   word_d = {8'h00, get_d ? gocfg_pkg::CH_G : gocfg_pkg::CH_S};
         GOCFG_CLOSE: word_d = {8'h00, gocfg_pkg::CH_CLOSE};
         GOCFG_FIELD: word_d = field_word(fld_d, idx_d);
         default:     word_d = '0;
      endcase
   end

   // data word straight from its register
   assign resp_data_out = word_q;

   // ****************************************************
   // assertions
   // ****************************************************
   sequence s_accept;
      cmd_valid_in && cmd_ready_out;
   endsequence
   sequence s_open;
      resp_valid_out && resp_is_char_out && resp_data_out[7:0] == gocfg_pkg::CH_OPEN;
   endsequence

   a_set_stores_kind: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      s_accept ##0 (!cmd_get_in && !cmd_wild_in[gocfg_pkg::WC_KIND] &&
                    !cmd_wild_in[gocfg_pkg::WC_IDX])
      |=> kind_q[$past(cmd_index_in)] == $past(cmd_datapoint_kind_in))
      else $error("set did not store datapoint kind");
   a_wild_keeps_delay: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      s_accept ##0 (cmd_wild_in[gocfg_pkg::WC_DELAY] && !cmd_wild_in[gocfg_pkg::WC_IDX])
      |=> dly_q[$past(cmd_index_in)] == $past(dly_q[cmd_index_in]))
      else $error("wildcard delay was changed");
   a_wild_all_len: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      s_accept ##0 (!cmd_get_in && cmd_wild_in[gocfg_pkg::WC_IDX] &&
                    !cmd_wild_in[gocfg_pkg::WC_LEN])
      |=> len_q[NUM_OBJ-1] == $past(cmd_object_length_type_in) && len_q[0] == len_q[NUM_OBJ-1])
      else $error("wildcard index did not reach all objects");
   a_interop_mode: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      (kind_q[obj_sel_in] != '0 && len_q[obj_sel_in] == '0) |=> obj_interop_out)
      else $error("interoperability mode not flagged");
   a_raw_length: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      (kind_q[obj_sel_in] == '0)
      |=> obj_raw_length_out == $past(len_q[obj_sel_in]) && !obj_interop_out)
      else $error("raw length not taken from length type");
   a_zero_delay_off: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      (dly_q[obj_sel_in] == '0) |=> !obj_timeout_en_out)
      else $error("timeout enabled with zero delay");
   a_time_base_sel: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      1'b1 |=> obj_time_base_out == $past(tx_q[obj_sel_in][gocfg_pkg::TB_HI:gocfg_pkg::TB_LO]))
      else $error("time base not from transmit policy");
   a_ack_opens: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      s_accept |=> s_open)
      else $error("acknowledge did not open with bracket");
   a_get_first_kind: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      (state_q == GOCFG_CLOSE && get_q && step)
      |=> resp_valid_out && !resp_is_char_out && resp_data_out == {8'h00, kind_q[idx_q]})
      else $error("first returned field is not datapoint kind");
endmodule
`default_nettype wire

// File: gocfg_host.sv
`default_nettype none
// ****************************
// host that drains the acks
// ****************************
module gocfg_host (
   // clock and reset
   input  wire logic                        clock_in,
   input  wire logic                        arst_n_in,
   // acknowledge stream
   input  wire logic                        resp_valid_in,
   input  wire logic                        resp_is_char_in,
   input  wire logic [gocfg_pkg::WORD_W-1:0] resp_data_in,
   input  wire logic                        slow_in,
   output logic                             resp_ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [gocfg_pkg::WORD_W:0] got[$];
   // slow host stalls every other cycle so words must stand
   always @(negedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) resp_ready_out <= 1'b0;
      else resp_ready_out <= slow_in ? ~resp_ready_out : 1'b1;
   end
   // keep each word taken for the bench to compare
   always @(posedge clock_in) begin
      if (resp_valid_in && resp_ready_out) got.push_back({resp_is_char_in, resp_data_in});
   end
endmodule
`default_nettype wire

// File: gocfg_pkg.sv
`default_nettype none
// ****************************************************
// shared constants for the object configuration block
// ****************************************************
package gocfg_pkg;
   // field widths
   localparam int KIND_W  = 8;
   localparam int LEN_W   = 8;
   localparam int FLAG_W  = 8;
   localparam int POL_W   = 16;
   localparam int DELAY_W = 16;
   localparam int WORD_W  = 16;
   // time base select field inside the transmit policy
   localparam int TB_LO   = 14;
   localparam int TB_HI   = 15;
   // reset values of each stored field
   localparam logic [KIND_W-1:0]  KIND_RST  = 8'h00;
   localparam logic [LEN_W-1:0]   LEN_RST   = 8'h00;
   localparam logic [FLAG_W-1:0]  FLAG_RST  = 8'h00;
   localparam logic [POL_W-1:0]   POL_RST   = 16'h0000;
   localparam logic [DELAY_W-1:0] DELAY_RST = 16'h0000;
   // wildcard mask bit positions
   localparam int WC_IDX   = 0;
   localparam int WC_KIND  = 1;
   localparam int WC_LEN   = 2;
   localparam int WC_FLAG  = 3;
   localparam int WC_TX    = 4;
   localparam int WC_IND   = 5;
   localparam int WC_DELAY = 6;
   localparam int WC_W     = 7;
   // acknowledge characters
   localparam logic [7:0] CH_OPEN  = 8'h3c;
   localparam logic [7:0] CH_CLOSE = 8'h3e;
   localparam logic [7:0] CH_O     = 8'h6f;
   localparam logic [7:0] CH_C     = 8'h63;
   localparam logic [7:0] CH_S     = 8'h73;
   localparam logic [7:0] CH_G     = 8'h67;
   // number of returned fields
   localparam logic [2:0] NUM_FIELDS = 3'h6;
   typedef enum logic { GOCFG_SET, GOCFG_GET } gocfg_op_t;
endpackage
`default_nettype wire

// File: group_object_config_commands_bench.sv
`default_nettype none
// ****************************
// bench for the config block
// ****************************
module group_object_config_commands_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_in, arst_n_in, cmd_valid, cmd_ready, cmd_get, slow;
   logic        resp_valid, resp_ready, resp_is_char, interop, tmo_en;
   logic [3:0]  cmd_index, obj_sel;
   logic [6:0]  wild;
   logic [7:0]  kind, len, flags, raw;
   logic [15:0] tx, ind, delay, resp_data, odelay;
   logic [1:0]  tbase;
   logic [7:0]  t_kind[16], t_len[16], t_flags[16];
   logic [15:0] t_tx[16], t_ind[16], t_delay[16];
   int          failures, samples_checked, cycles;
   gocfg_cmd gocfg_cmd_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_get_in(cmd_get),
      .cmd_index_in(cmd_index), .cmd_wild_in(wild), .cmd_datapoint_kind_in(kind),
      .cmd_object_length_type_in(len), .cmd_object_flag_set_in(flags),
      .cmd_transmit_policy_in(tx), .cmd_indication_policy_in(ind), .cmd_delay_in(delay),
      .resp_valid_out(resp_valid), .resp_ready_in(resp_ready),
      .resp_is_char_out(resp_is_char), .resp_data_out(resp_data), .obj_sel_in(obj_sel),
      .obj_interop_out(interop), .obj_raw_length_out(raw), .obj_timeout_en_out(tmo_en),
      .obj_time_base_out(tbase), .obj_delay_out(odelay));
   gocfg_host gocfg_host_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .resp_valid_in(resp_valid), .resp_is_char_in(resp_is_char), .resp_data_in(resp_data),
      .slow_in(slow), .resp_ready_out(resp_ready));
   // ****************************
   // compare and closing tasks
   // ****************************
   task automatic chk_word(input logic [16:0] got, input logic [16:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t word got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_stat(input logic [27:0] got, input logic [27:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t status got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // one command, its whole ack stream checked, then the shadow table updated for a set
   task automatic run(input logic g, input logic [3:0] ix, input logic [6:0] w,
                      input logic [7:0] k, l, f, input logic [15:0] t, i, d);
      logic [7:0]  ch[5];
      logic [15:0] fld[6];
      ch = '{gocfg_pkg::CH_OPEN, gocfg_pkg::CH_O, gocfg_pkg::CH_C,
             g ? gocfg_pkg::CH_G : gocfg_pkg::CH_S, gocfg_pkg::CH_CLOSE};
      fld = '{{8'h00, t_kind[ix]}, {8'h00, t_len[ix]}, {8'h00, t_flags[ix]},
              t_tx[ix], t_ind[ix], t_delay[ix]};
      gocfg_host_i.got.delete();
      @(negedge clock_in);
      {cmd_valid, cmd_get, cmd_index, wild, kind, len, flags, tx, ind, delay} <=
         {1'b1, g, ix, w, k, l, f, t, i, d};
      do @(posedge clock_in); while (cmd_ready !== 1'b1);
      @(negedge clock_in) cmd_valid <= 1'b0;
      for (int c = 0; c < 400 && gocfg_host_i.got.size() < (g ? 11 : 5); c++) @(posedge clock_in);
      for (int j = 0; j < 5; j++) chk_word(gocfg_host_i.got[j], {9'h100, ch[j]});
      if (g) begin
         for (int j = 0; j < 6; j++) chk_word(gocfg_host_i.got[5+j], {1'b0, fld[j]});
      end else begin
         for (int o = 0; o < 16; o++) if (w[0] || o == ix) begin
            if (!w[1]) t_kind[o] = k;
            if (!w[2]) t_len[o] = l;
            if (!w[3]) t_flags[o] = f;
            if (!w[4]) t_tx[o] = t;
            if (!w[5]) t_ind[o] = i;
            if (!w[6]) t_delay[o] = d;
         end
      end
   endtask
   // status of one object, expected from the shadow table
   task automatic stat(input logic [3:0] o);
      @(negedge clock_in) obj_sel <= o;
      @(negedge clock_in);
      chk_stat({interop, raw, tmo_en, tbase, odelay},
               {(t_kind[o] != 0 && t_len[o] == 0), (t_kind[o] == 0 ? t_len[o] : 8'h00),
                (t_delay[o] != 0), t_tx[o][15:14], t_delay[o]});
   endtask
   // model of the table after reset: every field clear
   task automatic clear_shadow;
      for (int o = 0; o < 16; o++) begin
         {t_kind[o], t_len[o], t_flags[o], t_tx[o], t_ind[o], t_delay[o]} = '0;
      end
   endtask
   // ****************************
   // clock, timeout and sequence
   // ****************************
   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   // a hung handshake ends the run as a mismatch
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      {arst_n_in, cmd_valid, cmd_get, slow, cmd_index, obj_sel, wild} = '0;
      {kind, len, flags, tx, ind, delay} = '0;
      clear_shadow();
      repeat (20) @(posedge clock_in);
      @(negedge clock_in) arst_n_in = 1'b1;
      run(1'b1, 4'h3, 7'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000);
      run(1'b0, 4'h2, 7'h00, 8'h01, 8'h00, 8'hdf, 16'h4001, 16'h0001, 16'h0000);
      stat(4'h2);
      slow <= 1'b1;
      run(1'b0, 4'h2, 7'h2a, 8'h55, 8'h05, 8'h11, 16'h8002, 16'h3333, 16'h0078);
      stat(4'h2);
      run(1'b0, 4'h2, 7'h7c, 8'h00, 8'h09, 8'h22, 16'h0000, 16'h0000, 16'h0000);
      stat(4'h2);
      run(1'b1, 4'h2, 7'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000);
      slow <= 1'b0;
      run(1'b0, 4'h9, 7'h3f, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0007);
      stat(4'h5);
      stat(4'h2);
      run(1'b1, 4'hf, 7'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000);
      run(1'b0, 4'h0, 7'h7b, 8'h00, 8'h03, 8'h00, 16'h0000, 16'h0000, 16'h0000);
      stat(4'h7);
      // reset between commands must clear the table; only object 7 is read back to check it
      @(negedge clock_in) arst_n_in = 1'b0;
      repeat (2) @(negedge clock_in);
      arst_n_in = 1'b1;
      clear_shadow();
      stat(4'h7);
      run(1'b1, 4'h7, 7'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000);
      finish_test();
   end
endmodule
`default_nettype wire
